// ==== hw/speed_sel_pkg.sv ====
// package: constants and types for the multispeed and jog select block
// Summary of operation
// - mode 00 is binary with sixteen speeds, mode 01 is bit with eight
// - binary index from four selectors, selector 1 least significant
// - input function codes 02..05 map to binary selectors 1..4
// - binary speeds 1..15 read the fifteen-entry speed table
// - speed 0 from base frequency or setting (operator) or analog (terminal)
// - table entries are 0.00 or start frequency up to maximum frequency
// - terminal source, reversible analog, negative sum reverses rotation
// - binary selection applied only after inputs stay stable for the delay
// - input function codes 32..38 map to bit selectors 1..7
// - bit speeds 1..7 read the first seven table entries
// - lowest-numbered active bit selector wins, none active gives speed 0
// - input function code 06 is the jog command
// - jog frequency is 0.0 or start frequency up to 9.99 Hz, output while jogging
// - jog stop method picks free-run, deceleration or dc braking, and run permission
// - modes 00..02: no jogging if forward run came before jog
// - modes 03..05: jog anyway, jog dropping first means free-run stop
// - each input normally open (00) or normally closed (01) before decoding
package speed_sel_pkg;
  // ---------------------------------------------------------------------------
  // widths and codes
  // ---------------------------------------------------------------------------
  localparam int          FREQ_W         = 16;       // hz in units of 0.01
  localparam int          NUM_TERM       = 8;
  localparam logic [1:0]  MODE_BINARY    = 2'h0;
  localparam logic [1:0]  MODE_BIT       = 2'h1;
  localparam logic [7:0]  FN_BIN_SEL0    = 8'h02;    // codes printed in decimal
  localparam logic [7:0]  FN_JOG        = 8'h06;
  localparam logic [7:0]  FN_BIT_SEL1    = 8'h20;    // decimal 32
  localparam logic [7:0]  FN_BIT_SEL7    = 8'h26;    // decimal 38
  localparam logic [1:0]  SRC_OPERATOR   = 2'h0;
  localparam logic [1:0]  SRC_TERMINAL   = 2'h1;
  localparam logic [FREQ_W-1:0] JOG_MAX_FREQ = 16'h03E7; // 9.99 Hz
  localparam logic [FREQ_W-1:0] FREQ_ZERO    = 16'h0000;
  localparam logic [2:0]  JOG_STOP_LAST_BLOCK = 3'h2; // 00..02 forbid run-first
  localparam logic [2:0]  JOG_STOP_MAX   = 3'h5;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  RST_SPEED_IDX  = 4'h0;
  localparam logic [15:0] RST_COUNT      = 16'h0000;
  localparam logic [15:0] SETTLE_W_MAX   = 16'hFFFF;

  typedef enum logic [1:0] {
    STOP_FREE = 2'b00,
    STOP_DECEL = 2'b01,
    STOP_DCBRAKE = 2'b10
  } stop_kind_t;

  typedef enum logic [1:0] {
    JOG_IDLE    = 2'b00,
    JOG_RUN     = 2'b01,
    JOG_BLOCKED = 2'b10
  } jog_state_t;
endpackage

// ==== hw/input_sync3.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module input_sync3 #(
  parameter int W = 8
) (
  input  wire logic         core_clk,  // system clock
  input  wire logic         rstn,      // sync reset, active low
  input  wire logic [W-1:0] raw,       // asynchronous pins
  output logic      [W-1:0] clean      // agreed level
);
  logic [W-1:0] s1_q, s2_q, s3_q, clean_q;
  logic [W-1:0] clean_d;

  // a bit changes only when stage two and three agree; stage one feeds only stage two
  always_comb begin
    clean_d = clean_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        clean_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      clean_q <= '0;
    end else begin
      s1_q    <= raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign clean = clean_q;
endmodule // input_sync3

// ==== hw/multispeed_jog_select.sv ====
// multispeed and jog frequency command selection
`timescale 1ns/1ns
module multispeed_jog_select (
  input  wire logic        core_clk,              // 250 MHz system clock
  input  wire logic        rstn,                  // sync reset, active low
  input  wire logic [7:0]  term_in,               // intelligent input pins 1..8
  input  wire logic        run_forward,           // forward run pin
  input  wire logic        run_reverse,           // reverse run pin
  input  wire logic [63:0] input_func_assign,     // 8 bits of function code per pin
  input  wire logic [7:0]  input_polarity_sel,    // 1 = normally closed
  input  wire logic [1:0]  multispeed_mode_sel,   // 00 binary, 01 bit
  input  wire logic [1:0]  freq_source_sel,       // 00 operator, 01 terminal
  input  wire logic [1:0]  motor_sel,             // base set 1..3 (0..2)
  input  wire logic [15:0] speed0_freq_m1,        // base speed, motor 1
  input  wire logic [15:0] speed0_freq_m2,        // base speed, motor 2
  input  wire logic [15:0] speed0_freq_m3,        // base speed, motor 3
  input  wire logic [15:0] output_freq_setting,   // operator setting
  input  wire logic        use_freq_setting,      // operator speed 0 from setting
  input  wire logic [239:0] speed_freq_table,     // speeds 1..15, 16 bits each
  input  wire logic [15:0] jog_freq,              // jog frequency
  input  wire logic [2:0]  jog_stop_method,       // 00..05
  input  wire logic [15:0] select_settle_delay,   // settle delay in clocks
  input  wire logic [15:0] start_freq,            // start frequency
  input  wire logic [15:0] max_freq,              // maximum frequency
  input  wire logic signed [16:0] analog_main,    // main analog command
  input  wire logic signed [16:0] analog_aux,     // auxiliary analog command
  input  wire logic        analog_reversible,     // analog mode allows reverse
  input  wire logic        motor_running,         // motor currently turning
  output logic [15:0]      freq_cmd,              // frequency command
  output logic             dir_reverse,           // commanded rotation reversed
  output logic             run_cmd,               // run request to drive
  output logic             jog_active,            // jogging in progress
  output logic [1:0]       stop_kind,             // stop method on next stop
  output logic [3:0]       speed_index            // applied speed number
);
  // ---------------------------------------------------------------------------
  // input synchronisation and polarity
  // ---------------------------------------------------------------------------
  logic [9:0] pins_s;
  logic [7:0] term_act;
  logic       fw_act, rv_act;

  input_sync3 #(.W(10)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .raw      ({run_reverse, run_forward, term_in}),
    .clean    (pins_s)
  );

  assign term_act = pins_s[7:0] ^ input_polarity_sel;
  assign fw_act   = pins_s[8];
  assign rv_act   = pins_s[9];

  // ---------------------------------------------------------------------------
  // function decoding
  // ---------------------------------------------------------------------------
  // or of all terminals assigned a given function code
  function automatic logic func_on(input logic [63:0] fa, input logic [7:0] act,
                                   input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int t = 0; t < speed_sel_pkg::NUM_TERM; t++) begin
      if (fa[t*8 +: 8] == code && act[t]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // clamp a table entry to 0 or start..max
  function automatic logic [15:0] legal_freq(input logic [15:0] f, input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [15:0] r;
    r = f;
    if (f == speed_sel_pkg::FREQ_ZERO) begin
      r = speed_sel_pkg::FREQ_ZERO;
    end else if (f < lo) begin
      r = lo;
    end else if (f > hi) begin
      r = hi;
    end
    return r;
  endfunction

  logic [3:0] bin_raw;
  logic [7:1] bit_sel;
  logic       jog_in;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_bin
      assign bin_raw[g] = func_on(input_func_assign, term_act,
                                  speed_sel_pkg::FN_BIN_SEL0 + 8'(g));
    end
    for (g = 1; g < 8; g++) begin : g_bit
      assign bit_sel[g] = func_on(input_func_assign, term_act,
                                  speed_sel_pkg::FN_BIT_SEL1 + 8'(g - 1));
    end
  endgenerate

  assign jog_in = func_on(input_func_assign, term_act, speed_sel_pkg::FN_JOG);

  // ---------------------------------------------------------------------------
  // binary selector settle filter
  // ---------------------------------------------------------------------------
  // slow delays hurt response; a zero delay applies the new pattern on the second clock
  logic [3:0]  bin_last_q, bin_last_d;
  logic [3:0]  bin_ok_q, bin_ok_d;
  logic [15:0] settle_q, settle_d;

  always_comb begin
    bin_last_d = bin_raw;
    bin_ok_d   = bin_ok_q;
    settle_d   = settle_q;
    if (bin_raw != bin_last_q) begin
      settle_d = speed_sel_pkg::RST_COUNT;
    end else if (settle_q >= select_settle_delay) begin
      bin_ok_d = bin_raw;
    end else begin
      settle_d = settle_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bin_last_q <= speed_sel_pkg::RST_SPEED_IDX;
      bin_ok_q   <= speed_sel_pkg::RST_SPEED_IDX;
      settle_q   <= speed_sel_pkg::RST_COUNT;
    end else begin
      bin_last_q <= bin_last_d;
      bin_ok_q   <= bin_ok_d;
      settle_q   <= settle_d;
    end
  end

  // ---------------------------------------------------------------------------
  // jog sequencing
  // ---------------------------------------------------------------------------
  speed_sel_pkg::jog_state_t jog_q, jog_d;
  logic fw_prev_q, jog_prev_q;
  logic run_allowed_first;
  logic run_any;
  logic free_stop_q, free_stop_d;

  assign run_allowed_first = (jog_stop_method > speed_sel_pkg::JOG_STOP_LAST_BLOCK);
  assign run_any = fw_act | rv_act;

  // jog must precede run; a run seen first blocks jogging in modes 00..02
  always_comb begin
    jog_d       = jog_q;
    free_stop_d = free_stop_q;
    case (jog_q)
      speed_sel_pkg::JOG_IDLE: begin
        if (jog_in && run_any) begin
          // run seen a clock ahead of jog, or a turning motor, refuses 00..02
          if (!run_allowed_first && (motor_running || (fw_prev_q && !jog_prev_q))) begin
            jog_d = speed_sel_pkg::JOG_BLOCKED;
          end else begin
            jog_d       = speed_sel_pkg::JOG_RUN;
            free_stop_d = 1'b0;
          end
        end else if (run_any && !jog_in && !run_allowed_first) begin
          jog_d = speed_sel_pkg::JOG_BLOCKED;
        end
        if (!run_any) begin
          free_stop_d = 1'b0;
        end
      end
      speed_sel_pkg::JOG_RUN: begin
        if (!jog_in && run_any) begin
          jog_d       = speed_sel_pkg::JOG_IDLE;
          free_stop_d = 1'b1;
        end else if (!run_any) begin
          jog_d = speed_sel_pkg::JOG_IDLE;
        end
      end
      speed_sel_pkg::JOG_BLOCKED: begin
        if (!run_any) begin
          jog_d = speed_sel_pkg::JOG_IDLE;
        end
      end
      default: begin
        jog_d = speed_sel_pkg::JOG_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      jog_q       <= speed_sel_pkg::JOG_IDLE;
      fw_prev_q   <= 1'b0;
      jog_prev_q  <= 1'b0;
      free_stop_q <= 1'b0;
    end else begin
      jog_q       <= jog_d;
      fw_prev_q   <= run_any;
      jog_prev_q  <= jog_in;
      free_stop_q <= free_stop_d;
    end
  end

  // ---------------------------------------------------------------------------
  // speed selection
  // ---------------------------------------------------------------------------
  logic [3:0]  idx_sel;
  logic [15:0] speed0_f;
  logic [15:0] table_f;
  logic signed [17:0] analog_sum;
  logic        analog_neg;
  logic [15:0] analog_mag;

  assign analog_sum = {analog_main[16], analog_main} + {analog_aux[16], analog_aux};
  assign analog_neg = analog_sum < 0;
  assign analog_mag = analog_neg ? 16'(-analog_sum) : 16'(analog_sum);

  // bit mode: lowest active selector wins, higher ones ignored
  always_comb begin
    idx_sel = speed_sel_pkg::RST_SPEED_IDX;
    if (multispeed_mode_sel == speed_sel_pkg::MODE_BIT) begin
      for (int s = 7; s >= 1; s--) begin
        if (bit_sel[s]) begin
          idx_sel = 4'(s);
        end
      end
    end else if (multispeed_mode_sel == speed_sel_pkg::MODE_BINARY) begin
      idx_sel = bin_ok_q;
    end
  end

  // speed 0 source depends on frequency source
  always_comb begin
    speed0_f = analog_mag;
    if (freq_source_sel == speed_sel_pkg::SRC_OPERATOR) begin
      if (use_freq_setting) begin
        speed0_f = output_freq_setting;
      end else begin
        case (motor_sel)
          2'h1:    speed0_f = speed0_freq_m2;
          2'h2:    speed0_f = speed0_freq_m3;
          default: speed0_f = speed0_freq_m1;
        endcase
      end
    end
  end

  assign table_f = (idx_sel == 4'h0) ? speed0_f :
                   legal_freq(speed_freq_table[(idx_sel - 4'h1)*16 +: 16],
                              start_freq, max_freq);

  // ---------------------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------------------
  logic [15:0] freq_q, freq_d, jog_f;
  logic        rev_q, rev_d, run_q, run_d, jact_q, jact_d;
  logic [1:0]  stop_q, stop_d;
  logic [3:0]  idx_q;

  assign jog_f = legal_freq(jog_freq, start_freq, speed_sel_pkg::JOG_MAX_FREQ);

  always_comb begin
    // follow the next state so jog flag and run request move on the same edge
    jact_d = (jog_d == speed_sel_pkg::JOG_RUN);
    freq_d = jact_d ? jog_f : table_f;
    run_d  = run_any && (jog_q != speed_sel_pkg::JOG_BLOCKED || !jog_in);
    rev_d  = rv_act && !fw_act;
    if (freq_source_sel == speed_sel_pkg::SRC_TERMINAL && analog_reversible &&
        idx_sel == 4'h0 && analog_neg && !jact_d) begin
      rev_d = !rev_d;
    end
    case (jog_stop_method)
      3'h0, 3'h3: stop_d = speed_sel_pkg::STOP_FREE;
      3'h1, 3'h4: stop_d = speed_sel_pkg::STOP_DECEL;
      3'h2, 3'h5: stop_d = speed_sel_pkg::STOP_DCBRAKE;
      default:    stop_d = speed_sel_pkg::STOP_DECEL;
    endcase
    if (free_stop_d) begin
      stop_d = speed_sel_pkg::STOP_FREE;
      run_d  = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      freq_q <= speed_sel_pkg::FREQ_ZERO;
      rev_q  <= 1'b0;
      run_q  <= 1'b0;
      jact_q <= 1'b0;
      stop_q <= speed_sel_pkg::STOP_FREE;
      idx_q  <= speed_sel_pkg::RST_SPEED_IDX;
    end else begin
      freq_q <= freq_d;
      rev_q  <= rev_d;
      run_q  <= run_d;
      jact_q <= jact_d;
      stop_q <= stop_d;
      idx_q  <= idx_sel;
    end
  end

  assign freq_cmd    = freq_q;
  assign dir_reverse = rev_q;
  assign run_cmd     = run_q;
  assign jog_active  = jact_q;
  assign stop_kind   = stop_q;
  assign speed_index = idx_q;
endmodule // multispeed_jog_select

// ==== test/multispeed_jog_select_checker.sv ====
// concurrent checks on the ports of the multispeed and jog select block
`timescale 1ns/1ns
module multispeed_jog_select_checker (
  input wire logic         core_clk,             // system clock
  input wire logic         rstn,                 // sync reset, active low
  input wire logic [7:0]   term_in,              // input pins
  input wire logic         run_forward,          // forward run pin
  input wire logic         run_reverse,          // reverse run pin
  input wire logic [1:0]   multispeed_mode_sel,  // speed mode
  input wire logic [239:0] speed_freq_table,     // speeds 1..15
  input wire logic [15:0]  jog_freq,             // jog frequency
  input wire logic [2:0]   jog_stop_method,      // jog stop code
  input wire logic [15:0]  select_settle_delay,  // settle clocks
  input wire logic [15:0]  start_freq,           // lower bound
  input wire logic [15:0]  max_freq,             // upper bound
  input wire logic [15:0]  freq_cmd,             // frequency command
  input wire logic         dir_reverse,          // reversed rotation
  input wire logic         run_cmd,              // run request
  input wire logic         jog_active,           // jogging
  input wire logic [1:0]   stop_kind,            // stop method
  input wire logic [3:0]   speed_index           // applied speed
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic [7:0]  term_q;
  logic [15:0] still_q;
  logic [15:0] still_d;
  logic [1:0]  runs_q;
  logic [15:0] run_still_q;
  logic [15:0] run_still_d;

  // ---------------------------------------------------------------------------
  // pin stability counter
  // ---------------------------------------------------------------------------
  // any pin change restarts the count; the settle filter restarts only on a binary selector change
  always_comb begin
    still_d = (term_in != term_q) ? 16'h0000 : still_q + 16'h0001;
    run_still_d = (runs_q != {run_reverse, run_forward}) ? 16'h0000 : run_still_q + 16'h0001;
  end
  always_ff @(posedge core_clk) begin
    term_q      <= term_in;
    still_q     <= still_d;
    runs_q      <= {run_reverse, run_forward};
    run_still_q <= run_still_d;
  end

  // zero is kept, anything else pulled into the legal band
  function automatic logic [15:0] lim(input logic [15:0] v, lo, hi);
    return (v == 16'h0000) ? v : (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  a_rst_clears_out: assert property ($rose(rstn) |-> freq_cmd == 16'h0000 && !run_cmd
    && !jog_active && speed_index == 4'h0) else $error("outputs not cleared by reset");
  a_bin_settle_wait: assert property (
    $changed(speed_index) && multispeed_mode_sel == speed_sel_pkg::MODE_BINARY
    && $stable(multispeed_mode_sel) && !jog_active && !$past(jog_active)
    |-> still_q >= select_settle_delay) else $error("binary index taken before settle");
  a_bit_index_range: assert property (
    multispeed_mode_sel == speed_sel_pkg::MODE_BIT
    && $past(multispeed_mode_sel, 3) == speed_sel_pkg::MODE_BIT |-> !speed_index[3])
    else $error("bit mode index above seven");
  a_table_freq_out: assert property (
    speed_index != 4'h0 && $stable(speed_index) && !jog_active && !$past(jog_active)
    |-> freq_cmd == lim(speed_freq_table[(speed_index - 1) * 16 +: 16], start_freq, max_freq))
    else $error("frequency does not match table entry");
  a_jog_freq_out: assert property (
    jog_active && $past(jog_active)
    |-> freq_cmd == lim(jog_freq, start_freq, speed_sel_pkg::JOG_MAX_FREQ))
    else $error("jog frequency not routed");
  a_jog_stop_kind: assert property (
    jog_active && $past(jog_active) |-> stop_kind == ((jog_stop_method >= 3'h3)
    ? jog_stop_method - 3'h3 : jog_stop_method)) else $error("jog stop kind wrong");
  a_jog_runs_drive: assert property (jog_active |-> run_cmd)
    else $error("jogging without run request");
  a_dir_hold_jog: assert property (jog_active && $past(jog_active) |-> $stable(dir_reverse))
    else $error("direction changed while jogging");
  // run pin moves legitimately flip direction, so only settled run pins are judged
  a_dir_at_speed0: assert property (
    $changed(dir_reverse) && run_still_q > 16'h0008
    |-> $past(speed_index) == 4'h0 && !$past(jog_active))
    else $error("direction changed away from speed 0");
endmodule // multispeed_jog_select_checker

bind multispeed_jog_select multispeed_jog_select_checker chk (.*);

// ==== test/terminal_driver_model.sv ====
// model of the external controller driving run and terminal pins
`timescale 1ns/1ns
module terminal_driver_model (
  input  wire logic core_clk,     // system clock
  output logic [7:0] term_in,     // intelligent input pins
  output logic       run_forward, // forward run pin
  output logic       run_reverse  // reverse run pin
);
  initial begin
    term_in = 8'h00;
    run_forward = 1'b0;
    run_reverse = 1'b0;
  end
  // contacts move just after an edge, never on it
  task automatic set_pins(input logic [7:0] v);
    @(posedge core_clk);
    #1 term_in = v;
  endtask
  task automatic set_run(input logic fw, input logic rv);
    @(posedge core_clk);
    #1 run_forward = fw;
    run_reverse = rv;
  endtask
  // jog pin first, run only once the jog level has had time to settle
  task automatic jog_then_run(input logic [7:0] v, input logic fw, input logic rv);
    set_pins(v);
    repeat (6) @(posedge core_clk);
    set_run(fw, rv);
  endtask
endmodule // terminal_driver_model

// ==== test/multispeed_jog_select_test.sv ====
// self-checking testbench for the multispeed and jog select block
`timescale 1ns/1ns
module multispeed_jog_select_test;
  localparam int SETTLE = 20; // settle delay in clocks
  logic               core_clk, rstn, use_freq_setting, analog_reversible, motor_running;
  logic               run_forward, run_reverse, dir_reverse, run_cmd, jog_active;
  logic [1:0]         multispeed_mode_sel, freq_source_sel, motor_sel, stop_kind;
  logic [2:0]         jog_stop_method;
  logic [3:0]         speed_index;
  logic [7:0]         term_in, input_polarity_sel;
  logic [15:0]        speed0_freq_m1, speed0_freq_m2, speed0_freq_m3, output_freq_setting;
  logic [15:0]        jog_freq, select_settle_delay, start_freq, max_freq, freq_cmd;
  logic [63:0]        input_func_assign;
  logic [239:0]       speed_freq_table;
  logic signed [16:0] analog_main, analog_aux;
  int                 err_count, checks;

  multispeed_jog_select DUT (.*);
  terminal_driver_model ctl (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [15:0] lim(input logic [15:0] v, lo, hi);
    return (v == 16'h0000) ? v : (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // a hang is cut well beyond the roughly 1200 clocks the tests need
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    err_count = 0;
    checks = 0;
    rstn = 1'b0;
    {use_freq_setting, analog_reversible, motor_running} = 3'h0;
    {multispeed_mode_sel, freq_source_sel, motor_sel} = 6'h00;
    jog_stop_method = 3'h0;
    input_polarity_sel = 8'h00;
    {speed0_freq_m2, speed0_freq_m3, output_freq_setting} = {16'h0300, 16'h0400, 16'h0500};
    speed0_freq_m1 = 16'h0200;
    jog_freq = 16'h0400; // above 9.99 Hz, must be limited
    select_settle_delay = 16'(SETTLE);
    start_freq = 16'h0032;
    max_freq = 16'h1388;
    analog_main = 17'sh00000;
    analog_aux = 17'sh00000;
    for (int n = 1; n < 16; n++) speed_freq_table[(n-1)*16 +: 16] = 16'h0123 * n[15:0];
    speed_freq_table[47:32] = 16'h0000;   // zero entry is legal
    speed_freq_table[79:64] = 16'h0010;   // below start frequency
    speed_freq_table[239:224] = 16'hFFFF; // above maximum
    input_func_assign = 64'h0000_0006_0504_0302; // pins 1..4 binary, pin 5 jog
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    // binary walk through speeds 1..15
    for (int n = 1; n < 16; n++) begin
      ctl.set_pins(n[7:0]);
      wait_clk(SETTLE + 12);
      check({12'h000, speed_index}, n[15:0]);
      check(freq_cmd, lim(speed_freq_table[(n-1)*16 +: 16], start_freq, max_freq));
    end
    // a glitch shorter than the settle delay is never applied
    ctl.set_pins(8'h09);
    wait_clk(10);
    check({12'h000, speed_index}, 16'h000F);
    ctl.set_pins(8'h0F);
    wait_clk(SETTLE + 12);
    check({12'h000, speed_index}, 16'h000F);
    // bit mode, pin 1 normally closed, pin 8 jog
    multispeed_mode_sel = speed_sel_pkg::MODE_BIT;
    input_func_assign = 64'h0626_2524_2322_2120;
    input_polarity_sel = 8'h01;
    for (int k = 1; k < 8; k++) begin
      ctl.set_pins(((8'h7F << (k - 1)) & 8'h7F) ^ 8'h01);
      wait_clk(12);
      check({12'h000, speed_index}, k[15:0]);
      check(freq_cmd, lim(speed_freq_table[(k-1)*16 +: 16], start_freq, max_freq));
    end
    ctl.set_pins(8'h01);
    wait_clk(12);
    check({12'h000, speed_index}, 16'h0000);
    check(freq_cmd, speed0_freq_m1);
    // operator speed 0 from the setting, then from motor base sets 2 and 3
    use_freq_setting = 1'b1;
    wait_clk(2);
    check(freq_cmd, output_freq_setting);
    use_freq_setting = 1'b0;
    for (int m = 1; m < 3; m++) begin
      motor_sel = m[1:0];
      wait_clk(2);
      check(freq_cmd, (m == 1) ? speed0_freq_m2 : speed0_freq_m3);
    end
    motor_sel = 2'h0;
    // every jog stop method, proper order then run first
    for (int j = 0; j < 6; j++) begin
      jog_stop_method = j[2:0];
      jog_freq = (j < 3) ? 16'h0400 : 16'h0010;
      ctl.jog_then_run(8'h81, j != 5, j == 5);
      wait_clk(12);
      check({15'h0000, jog_active}, 16'h0001);
      check({15'h0000, run_cmd}, 16'h0001);
      check(freq_cmd, lim(jog_freq, start_freq, speed_sel_pkg::JOG_MAX_FREQ));
      check({14'h0000, stop_kind}, 16'(j % 3));
      ctl.set_run(1'b0, 1'b0);
      ctl.set_pins(8'h01);
      wait_clk(12);
      ctl.set_run(1'b1, 1'b0);
      wait_clk(12);
      ctl.set_pins(8'h81);
      wait_clk(12);
      check({15'h0000, jog_active}, {15'h0000, j > 2});
      if (j > 2) begin
        ctl.set_pins(8'h01);
        wait_clk(12);
        check({15'h0000, run_cmd}, 16'h0000);
        check({14'h0000, stop_kind}, {14'h0000, speed_sel_pkg::STOP_FREE});
      end
      ctl.set_run(1'b0, 1'b0);
      ctl.set_pins(8'h01);
      wait_clk(12);
    end
    // jog refused while the motor turns, checked with method 01
    jog_stop_method = 3'h1;
    motor_running = 1'b1;
    ctl.jog_then_run(8'h81, 1'b1, 1'b0);
    wait_clk(12);
    check({15'h0000, jog_active}, 16'h0000);
    check({15'h0000, run_cmd}, 16'h0000);
    ctl.set_run(1'b0, 1'b0);
    ctl.set_pins(8'h01);
    motor_running = 1'b0;
    wait_clk(12);
    // negative analog sum reverses rotation at speed 0
    freq_source_sel = speed_sel_pkg::SRC_TERMINAL;
    analog_reversible = 1'b1;
    analog_main = -17'sd300;
    analog_aux = 17'sd100;
    ctl.set_run(1'b1, 1'b0);
    wait_clk(12);
    check({15'h0000, dir_reverse}, 16'h0001);
    check(freq_cmd, 16'h00C8);
    analog_aux = 17'sd400;
    wait_clk(12);
    check({15'h0000, dir_reverse}, 16'h0000);
    check(freq_cmd, 16'h0064);
    ctl.set_run(1'b0, 1'b0);
    wait_clk(4);
    wrap_up();
  end
endmodule // multispeed_jog_select_test
